/* File: src/timer8_pwm_and_serial_clock.v */
// Behaviour
// RULE1: In PWM mode one period is a full 8-bit counter run ending at overflow.
// RULE2: Polarity clear: PWM source high while counter runs from zero to compare.
// RULE3: After compare match, PWM source low until counter overflows.
// RULE4: With counting stopped, PWM output is held high.
// RULE5: Additional pulse mode lengthens chosen periods by one count in a 4-period frame.
// RULE6: Position field: 00 none, 01 period 2, 10 periods 1,3, 11 periods 1,2,3.
// RULE7: With additional pulses, interrupt once per frame at the fourth period.
// RULE8: Writing the compare register clears the binary counter.
// RULE9: Selecting PWM changes the initial output level from low to high.
// RULE10: PWM operation when mode bit 4 is one and bit 5 is zero.
// RULE11: Mode bit 3 one runs the timer, zero stops it.
// RULE12: Mode bits 2..0 pick the count clock; X01 selects the prescaler.
// RULE13: Prescaler gives half system clock when bits 2..1 are X0 and bit 0 set.
// RULE14: Serial transfer clock is half the compare-set frequency.
// RULE15: Timer 1 feeds serial 0, timer 2 serial 0 and 2, timer 3 serial 2.
// RULE16: Only timers 0 and 2 provide PWM, each on its own pin.
// RULE17: Software uses normal mode, PWM and measure flags zero, for serial clocks.
// RULE18: Software stops counting, sets mode, clock and compare, then enables.
// RULE19: Normal mode: compare match clears counter and inverts timer output.
// RULE20: Compare write while stopped forces the timer output low.
// RULE21: Counter increments per count clock and wraps from 0xFF to zero.
// RULE22: The additional pulse frame counter restarts at period 0 when enabled.
`timescale 1ns/1ns
`include "timer8_defs.vh"

// ****************************************
// One 8-bit timer channel
// ****************************************
module timer8_channel #(
    parameter PWM_CAPABLE = 1
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Configuration
    input  wire [7:0] modeReg,
    input  wire [7:0] prescaleReg,
    input  wire [7:0] compareReg,
    input  wire       compareWr,
    // Results
    output reg        pinOut_q,
    output reg        irq_q,
    output reg  [7:0] binaryCounter_q
);
    reg  [1:0] prescaleCnt_q;
    reg  [1:0] frame_q;
    reg        toggle_q;
    reg        countTick;
    reg        addThis;
    wire       running  = modeReg[`MODE_EN];
    wire       pwmMode  = (PWM_CAPABLE != 0) && modeReg[`MODE_PWM]
                          && !modeReg[`MODE_MEAS]; // [RULE10] [RULE16]
    wire       addMode  = modeReg[`MODE_ADDP];
    wire [1:0] addPos   = prescaleReg[`CK_APOS_HI:`CK_APOS_LO];
    wire       overflow = (binaryCounter_q == `CNT_MAX);
    wire       match    = (binaryCounter_q == compareReg);
    wire       psTick;
    wire       pwmHigh;

    // ****************************************
    // Count clock
    // ****************************************
    // Prescaler: tap 0 halves the system clock, tap 1 quarters it
    assign psTick = prescaleReg[`CK_PS_EN] &&
                    (prescaleReg[`CK_TAP] ? (prescaleCnt_q == 2'h3)
                                          : prescaleCnt_q[0]); // [RULE13]

    // Count clock selection; sources outside this block never tick
    always @* begin
        case (modeReg[1:0])
            `SRC_SYS:      countTick = running;
            `SRC_PRESCALE: countTick = running && psTick; // [RULE12] [RULE11]
            default:       countTick = 1'b0;
        endcase
    end

    // ****************************************
    // PWM waveform
    // ****************************************
    // Which frame periods get the extra count
    always @* begin
        case (addPos)
            2'h1:    addThis = (frame_q == 2'h2);
            2'h2:    addThis = (frame_q == 2'h1) || (frame_q == 2'h3);
            2'h3:    addThis = (frame_q != 2'h0);
            default: addThis = 1'b0;
        endcase // [RULE6]
    end

    // High below compare; one extra count when the frame slot asks for it
    assign pwmHigh = (binaryCounter_q < compareReg) ||
                     (match && addMode && addThis); // [RULE2] [RULE3] [RULE5]

    // ****************************************
    // Counters
    // ****************************************
    // Phase restarts when disabled, so the first tick is always one tap away
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prescaleCnt_q <= 2'h0;
        end else if (!prescaleReg[`CK_PS_EN]) begin
            prescaleCnt_q <= 2'h0;
        end else begin
            prescaleCnt_q <= prescaleCnt_q + 2'h1;
        end
    end

    // A compare write outranks a tick, so the count restarts exactly at zero
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            binaryCounter_q <= `CNT_ZERO;
            frame_q         <= 2'h0;
            toggle_q        <= 1'b0;
            irq_q           <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            if (!running) begin
                frame_q <= 2'h0; // [RULE22]
            end
            if (compareWr) begin
                binaryCounter_q <= `CNT_ZERO; // [RULE8]
                if (!running) begin
                    toggle_q <= 1'b0; // [RULE20]
                end
            end else if (countTick && pwmMode) begin
                binaryCounter_q <= binaryCounter_q + 8'h01; // [RULE21] [RULE1]
                if (overflow) begin
                    frame_q <= frame_q + 2'h1;
                    irq_q   <= !addMode || (frame_q == `FRAME_LAST); // [RULE7]
                end
            end else if (countTick) begin
                if (match) begin
                    binaryCounter_q <= `CNT_ZERO; // [RULE19]
                    toggle_q        <= !toggle_q; // [RULE19] [RULE14]
                    irq_q           <= 1'b1;
                end else begin
                    binaryCounter_q <= binaryCounter_q + 8'h01; // [RULE21]
                end
            end
        end
    end

    // ****************************************
    // Pin
    // ****************************************
    // Pin level: PWM idles high when stopped, normal mode shows the toggle
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinOut_q <= 1'b0;
        end else if (pwmMode) begin
            if (!running) begin
                pinOut_q <= 1'b1; // [RULE4] [RULE9]
            end else begin
                pinOut_q <= pwmHigh ^ modeReg[`MODE_POL];
            end
        end else begin
            pinOut_q <= toggle_q;
        end
    end
endmodule

// ****************************************
// Top: AHB-Lite register file and four timers
// ****************************************
module timer8_pwm_and_serial_clock (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Timer pins and events
    output reg  [3:0]  timerIoPin,
    output reg  [3:0]  timerIrq,
    // Serial transfer clocks
    output reg         serialClk0,
    output reg         serialClk2
);
    reg  [7:0]  modeQ    [0:3];
    reg  [7:0]  prescQ   [0:3];
    reg  [7:0]  cmpQ     [0:3];
    reg  [7:0]  routeQ;
    reg  [15:0] addrIdx_q;
    reg         wrPend_q;
    reg         rdPend_q;
    reg  [7:0]  rdMux;
    reg  [3:0]  cmpWr;
    wire [3:0]  pinW;
    wire [3:0]  irqW;
    wire [7:0]  cntW     [0:3];
    wire        addrPhase = hsel && htrans[1] && hready;
    integer     i;

    // ****************************************
    // Timer channels
    // ****************************************
    // Only timers 0 and 2 are built with the PWM path
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : chan
            timer8_channel #(
                .PWM_CAPABLE ((g == 0) || (g == 2)) // [RULE16]
            ) u_chan (
                .mclk            (mclk),
                .rst_n           (rst_n),
                .modeReg         (modeQ[g]),
                .prescaleReg     (prescQ[g]),
                .compareReg      (cmpQ[g]),
                .compareWr       (cmpWr[g]),
                .pinOut_q        (pinW[g]),
                .irq_q           (irqW[g]),
                .binaryCounter_q (cntW[g])
            );
        end
    endgenerate

    // ****************************************
    // Bus phases
    // ****************************************
    // Reads take one wait state so a write just before is already visible
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            addrIdx_q <= 16'h0000;
            wrPend_q  <= 1'b0;
            rdPend_q  <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= 32'h00000000;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rdPend_q) begin
                rdPend_q  <= 1'b0;
                hreadyout <= 1'b1;
                hrdata    <= {24'h000000, rdMux};
            end else begin
                wrPend_q <= addrPhase && hwrite;
                rdPend_q <= addrPhase && !hwrite;
                if (addrPhase) begin
                    addrIdx_q <= haddr[17:2];
                    hreadyout <= hwrite;
                end
            end
        end
    end

    // Write strobes for compare registers
    always @* begin
        cmpWr = 4'h0;
        if (wrPend_q) begin
            case (addrIdx_q)
                `IDX_T0_CMP: cmpWr = 4'h1;
                `IDX_T1_CMP: cmpWr = 4'h2;
                `IDX_T2_CMP: cmpWr = 4'h4;
                `IDX_T3_CMP: cmpWr = 4'h8;
                default:     cmpWr = 4'h0;
            endcase
        end
    end

    // ****************************************
    // Register file
    // ****************************************
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 4; i = i + 1) begin
                modeQ[i]  <= `REG_RESET;
                prescQ[i] <= `REG_RESET;
                cmpQ[i]   <= `REG_RESET;
            end
            routeQ <= `REG_RESET;
        end else if (wrPend_q) begin
            case (addrIdx_q)
                `IDX_T0_MODE: modeQ[0]  <= hwdata[7:0];
                `IDX_T1_MODE: modeQ[1]  <= hwdata[7:0];
                `IDX_T2_MODE: modeQ[2]  <= hwdata[7:0];
                `IDX_T3_MODE: modeQ[3]  <= hwdata[7:0];
                `IDX_T0_CK:   prescQ[0] <= hwdata[7:0];
                `IDX_T1_CK:   prescQ[1] <= hwdata[7:0];
                `IDX_T2_CK:   prescQ[2] <= hwdata[7:0];
                `IDX_T3_CK:   prescQ[3] <= hwdata[7:0];
                `IDX_T0_CMP:  cmpQ[0]   <= hwdata[7:0];
                `IDX_T1_CMP:  cmpQ[1]   <= hwdata[7:0];
                `IDX_T2_CMP:  cmpQ[2]   <= hwdata[7:0];
                `IDX_T3_CMP:  cmpQ[3]   <= hwdata[7:0];
                `IDX_ROUTE:   routeQ    <= {6'h00, hwdata[1:0]};
                default:      routeQ    <= routeQ;
            endcase
        end
    end

    // Unmapped indices read as zero
    always @* begin
        case (addrIdx_q)
            `IDX_T0_MODE: rdMux = modeQ[0];
            `IDX_T1_MODE: rdMux = modeQ[1];
            `IDX_T2_MODE: rdMux = modeQ[2];
            `IDX_T3_MODE: rdMux = modeQ[3];
            `IDX_T0_CK:   rdMux = prescQ[0];
            `IDX_T1_CK:   rdMux = prescQ[1];
            `IDX_T2_CK:   rdMux = prescQ[2];
            `IDX_T3_CK:   rdMux = prescQ[3];
            `IDX_T0_CMP:  rdMux = cmpQ[0];
            `IDX_T1_CMP:  rdMux = cmpQ[1];
            `IDX_T2_CMP:  rdMux = cmpQ[2];
            `IDX_T3_CMP:  rdMux = cmpQ[3];
            `IDX_ROUTE:   rdMux = routeQ;
            `IDX_STATUS:  rdMux = {4'h0, pinW};
            `IDX_CNT0:    rdMux = cntW[0];
            `IDX_CNT1:    rdMux = cntW[1];
            `IDX_CNT2:    rdMux = cntW[2];
            `IDX_CNT3:    rdMux = cntW[3];
            default:      rdMux = 8'h00;
        endcase
    end

    // ****************************************
    // Pins and serial clock routing
    // ****************************************
    // Serial clocks are the toggled timer outputs, so half the compare rate
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timerIoPin <= 4'h0;
            timerIrq   <= 4'h0;
            serialClk0 <= 1'b0;
            serialClk2 <= 1'b0;
        end else begin
            timerIoPin <= pinW;
            timerIrq   <= irqW;
            serialClk0 <= routeQ[`ROUTE_S0_T2] ? pinW[2] : pinW[1]; // [RULE15] [RULE14]
            serialClk2 <= routeQ[`ROUTE_S2_T3] ? pinW[3] : pinW[2]; // [RULE15]
        end
    end
endmodule

/* File: inc/timer8_defs.vh */
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_T2_CMP   16'h0F5A
`define IDX_T2_CK    16'h0F5E
`define IDX_T0_CMP   16'h3F52
`define IDX_T0_MODE  16'h3F54
`define IDX_T0_CK    16'h3F56
`define IDX_T2_MODE  16'h3F5C
`define IDX_T1_CMP   16'h3F53
`define IDX_T1_MODE  16'h3F55
`define IDX_T1_CK    16'h3F57
`define IDX_T3_CMP   16'h0F5B
`define IDX_T3_MODE  16'h3F5D
`define IDX_T3_CK    16'h0F5F
`define IDX_ROUTE    16'h3F60
`define IDX_STATUS   16'h3F61
`define IDX_CNT0     16'h3F64
`define IDX_CNT1     16'h3F65
`define IDX_CNT2     16'h3F66
`define IDX_CNT3     16'h3F67

// Mode register fields
`define MODE_CKSEL_HI  2
`define MODE_CKSEL_LO  0
`define MODE_EN        3
`define MODE_PWM       4
`define MODE_MEAS      5
`define MODE_POL       6
`define MODE_ADDP      7

// Prescale select register fields
`define CK_PS_EN       0
`define CK_TAP         1
`define CK_APOS_HI     5
`define CK_APOS_LO     4

// Count clock source codes (bits 1:0 of the select field)
`define SRC_SYS        2'h0
`define SRC_PRESCALE   2'h1

// Route register fields
`define ROUTE_S0_T2    0
`define ROUTE_S2_T3    1

`define REG_RESET      8'h00
`define CNT_ZERO       8'h00
`define CNT_MAX        8'hFF
`define FRAME_LAST     2'h3

`endif

/* File: bench/timer8_props.sv */
`timescale 1ns/1ns
// **************************
// Port checker
// **************************
module timer8_props (
    // Clock and reset
    input wire        mclk,
    input wire        rst_n,
    // Bus
    input wire        hsel,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    // Timer side
    input wire [3:0]  timerIoPin,
    input wire [3:0]  timerIrq,
    input wire        serialClk0,
    input wire        serialClk2
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire rdGo = hsel && htrans[1] && hready && !hwrite;
    wire wrGo = hsel && htrans[1] && hready && hwrite;
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_read_wait: assert property (rdGo |=> s_rd_wait)
        else $error("read wait state wrong");
    a_write_fast: assert property (wrGo |=> hreadyout)
        else $error("write stalled");
    a_ready_idle: assert property (hreadyout && !rdGo |=> hreadyout)
        else $error("stray wait state");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
    a_high_zero: assert property (hrdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_route_zero: assert property (serialClk0 == timerIoPin[1])
        else $error("serial clock 0 source wrong");
    a_route_two: assert property (serialClk2 == timerIoPin[2])
        else $error("serial clock 2 source wrong");
    a_toggle_irq: assert property (timerIrq[1] |=>
        timerIoPin[1] != $past(timerIoPin[1]))
        else $error("match without output toggle");
endmodule

bind timer8_pwm_and_serial_clock timer8_props timer8_props_i (
    .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .timerIoPin(timerIoPin), .timerIrq(timerIrq),
    .serialClk0(serialClk0), .serialClk2(serialClk2)
);

/* File: bench/serial_load_model.sv */
`timescale 1ns/1ns
// **************************
// Serial side: rising-edge spacing of transfer clocks
// **************************
module serial_load_model (
    // Clock
    input wire  mclk,
    // Transfer clocks
    input wire  serialClk0,
    input wire  serialClk2,
    // Measured periods in mclk cycles
    output int  period0,
    output int  period2
);
    int   cnt0 = 0;
    int   cnt2 = 0;
    logic last0 = 1'b0;
    logic last2 = 1'b0;
    always @(posedge mclk) begin
        last0 <= serialClk0;
        last2 <= serialClk2;
        cnt0 <= (serialClk0 && !last0) ? 1 : cnt0 + 1;
        cnt2 <= (serialClk2 && !last2) ? 1 : cnt2 + 1;
        if (serialClk0 && !last0) period0 <= cnt0;
        if (serialClk2 && !last2) period2 <= cnt2;
    end
endmodule

/* File: bench/timer8_pwm_and_serial_clock_test.sv */
`timescale 1ns/1ns
`include "timer8_defs.vh"
module timer8_pwm_and_serial_clock_test;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    wire  [31:0] hrdata;
    wire         hready;
    wire         hresp;
    wire  [3:0]  pin;
    wire  [3:0]  irq;
    wire         sc0;
    wire         sc2;
    int          period0;
    int          period2;
    int          failures = 0;
    int          num_checks = 0;
    int          irqCnt2 = 0;
    int          c;
    int          n;
    int          w;
    logic [7:0]  rv;
    logic [15:0] regs[6] = '{`IDX_T0_CMP, `IDX_T0_MODE, `IDX_T0_CK,
                             `IDX_T2_CMP, `IDX_T2_MODE, `IDX_T2_CK};

    timer8_pwm_and_serial_clock timer8_pwm_and_serial_clock_i (
        .mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .timerIoPin(pin),
        .timerIrq(irq), .serialClk0(sc0), .serialClk2(sc2));
    serial_load_model serial_load_model_i (
        .mclk(mclk), .serialClk0(sc0), .serialClk2(sc2),
        .period0(period0), .period2(period2));

    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (irq[2] === 1'b1) irqCnt2 <= irqCnt2 + 1;
    end

    function automatic int addp(input int pos, input int slot);
        case (pos)
            1: return slot == 2;
            2: return slot == 1 || slot == 3;
            3: return slot != 0;
            default: return 0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
        htrans <= 2'h2;
        haddr <= {14'h0, idx, 2'h0};
        hwrite <= wr;
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge mclk);
        while (hready !== 1'b1) @(posedge mclk);
        rv = hrdata[7:0];
    endtask
    // Bounded so a stuck pin ends in a mismatch, not a hang
    task automatic hold(input int p, input logic v, output int k);
        k = 0;
        while (pin[p] === v && k < 2000) begin
            k++;
            @(posedge mclk);
        end
        if (k >= 2000) begin
            failures++;
            $display("unexpected at %0t: pin %0d stuck, got %h expected %h", $time, p, v, !v);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #500000;
        failures++;
        give_verdict();
    end

    initial begin
        void'($urandom(67));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        foreach (regs[i]) begin
            bus(regs[i], 0, 0);
            chk(rv, `REG_RESET);
            c = $urandom_range(255) & 8'hF7;
            bus(regs[i], 1, c);
            bus(regs[i], 0, 0);
            chk(rv, c);
            bus(regs[i], 1, 0);
        end
        bus(16'h0100, 1, 8'h5A);
        bus(16'h0100, 0, 0);
        chk(rv, 0);
        $display("registers done");
        repeat (4) begin
            c = $urandom_range(1, 6);
            bus(`IDX_T1_MODE, 1, 0);
            bus(`IDX_T2_MODE, 1, 0);
            bus(`IDX_T2_CK, 1, 8'h01);
            bus(`IDX_T1_CMP, 1, c);
            bus(`IDX_T2_CMP, 1, c);
            bus(`IDX_T2_MODE, 1, 8'h01);
            bus(`IDX_T1_MODE, 1, 8'h08);
            bus(`IDX_T2_MODE, 1, 8'h09);
            repeat (100) @(posedge mclk);
            chk(period0, 2 * (c + 1));
            chk(period2, 4 * (c + 1));
        end
        bus(`IDX_T1_CMP, 1, 8'hFF);
        repeat (100) @(posedge mclk);
        bus(`IDX_T1_CMP, 1, 8'hFF);
        bus(`IDX_CNT1, 0, 0);
        chk(rv < 8'h08, 1);
        hold(1, 0, n);
        bus(`IDX_T1_MODE, 1, 0);
        bus(`IDX_T1_CMP, 1, 8'h10);
        repeat (3) @(posedge mclk);
        chk(pin[1], 0);
        $display("serial clocks done");
        for (int pol = 0; pol < 2; pol++) begin
            c = $urandom_range(1, 254);
            bus(`IDX_T0_MODE, 1, 0);
            bus(`IDX_T0_CMP, 1, c);
            bus(`IDX_T0_MODE, 1, 8'h10 | (pol << 6));
            repeat (3) @(posedge mclk);
            chk(pin[0], 1);
            bus(`IDX_T0_MODE, 1, 8'h18 | (pol << 6));
            hold(0, 1, n);
            hold(0, 0, n);
            hold(0, 1, w);
            chk(w, pol ? 256 - c : c);
            hold(0, 0, n);
            chk(w + n, 256);
            bus(`IDX_T0_MODE, 1, 8'h10 | (pol << 6));
            repeat (3) @(posedge mclk);
            chk(pin[0], 1);
        end
        bus(`IDX_T0_MODE, 1, 0);
        bus(`IDX_T0_CMP, 1, c);
        bus(`IDX_T0_MODE, 1, 8'h30);
        repeat (3) @(posedge mclk);
        chk(pin[0], 0);
        $display("pwm done");
        for (int pos = 0; pos < 4; pos++) begin
            c = $urandom_range(1, 200);
            bus(`IDX_T2_MODE, 1, 0);
            bus(`IDX_T2_CK, 1, pos << 4);
            bus(`IDX_T2_CMP, 1, c);
            bus(`IDX_T2_MODE, 1, 8'h90);
            bus(`IDX_T2_MODE, 1, 8'h98);
            n = 0;
            while (irq[2] !== 1'b1 && n < 3000) begin
                n++;
                @(posedge mclk);
            end
            chk(irq[2], 1);
            // The pulse that ended the wait was counted at that edge; one more edge lets w include it
            @(posedge mclk);
            w = irqCnt2;
            for (int k = 0; k < 4; k++) begin
                hold(2, 0, n);
                hold(2, 1, n);
                chk(n, c + addp(pos, k));
            end
            hold(2, 0, n);
            @(posedge mclk);
            chk(irqCnt2 - w, 1);
        end
        $display("additional pulse done");
        give_verdict();
    end
endmodule
